// File: hdl/dslsc_consts.svh
/*
 * Constants of the lane switch configuration bank: register offsets,
 * reset values, field positions and the serial slave address prefix.
 * Assumes it is included by bare name from files that need the values.
 */
`ifndef DSLSC_CONSTS_SVH
`define DSLSC_CONSTS_SVH

`define DSLSC_OFS_FAST_MODES 8'h00
`define DSLSC_OFS_LS_MODES 8'h01
`define DSLSC_OFS_RX_SET 8'h10
`define DSLSC_OFS_IN_TERM 8'h11
`define DSLSC_OFS_IN_EQ 8'h14
`define DSLSC_OFS_TX_SET 8'h20
`define DSLSC_OFS_POLARITY 8'h80
`define DSLSC_OFS_A_ROUTE 8'h81
`define DSLSC_OFS_B_ROUTE 8'h82

`define DSLSC_RST_FAST_MODES 8'h40
`define DSLSC_RST_LS_MODES 8'hC0
`define DSLSC_RST_RX_SET 8'h01
`define DSLSC_RST_IN_TERM 8'h00
`define DSLSC_RST_IN_EQ 8'hFF
`define DSLSC_RST_TX_SET 8'h03
`define DSLSC_RST_POLARITY 8'h00
`define DSLSC_RST_A_ROUTE 8'hE4
`define DSLSC_RST_B_ROUTE 8'hE4

`define DSLSC_FAST_ON_BIT 6
`define DSLSC_FAST_SEL_BIT 0
`define DSLSC_LS_LOCK_BIT 7
`define DSLSC_LS_EN_BIT 6
`define DSLSC_LS_SEL_BIT 0
`define DSLSC_TERM_ALWAYS_BIT 0
`define DSLSC_PREEMPH_MSB 3
`define DSLSC_PREEMPH_LSB 2
`define DSLSC_OUT_TERM_BIT 1
`define DSLSC_OUT_CUR_BIT 0

`define DSLSC_SLAVE_PREFIX 6'h24
`define DSLSC_UNMAPPED_READ 8'h00

`endif

// File: hdl/dslsc_pkg.sv
/*
 * Types of the lane switch configuration bank: serial slave states and
 * the bundle of switch controls driven to the analog lanes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dslsc_pkg;

    typedef enum logic [3:0] {
        SER_IDLE = 4'b0000,
        SER_DEV = 4'b0001,
        SER_DEV_ACK = 4'b0010,
        SER_REG = 4'b0011,
        SER_REG_ACK = 4'b0100,
        SER_WDATA = 4'b0101,
        SER_WDATA_ACK = 4'b0110,
        SER_RDATA = 4'b0111,
        SER_RDATA_ACK = 4'b1000,
        SER_RD_LOAD = 4'b1001
    } dslsc_ser_e;

    typedef struct packed {
        logic fastSwitchOn;
        logic standby;
        logic fastSourceSel;
        logic lowspeedConnA;
        logic lowspeedConnB;
        logic [3:0] termEnA;
        logic [3:0] termEnB;
        logic [3:0] eqHighA;
        logic [3:0] eqHighB;
        logic [1:0] outPreemphLevel;
        logic outTermOn;
        logic outDriveCurrent;
    } dslsc_ctrl_s;

endpackage : dslsc_pkg

// File: hdl/dslsc_lane_router.sv
/*
 * Lane router: per-lane polarity swap of each source, then selection of
 * the source lane that drives each output lane.
 * Assumes lane legs are sampled digital levels; the caller registers them.
 */
`timescale 1ns/100ps
`default_nettype none

module dslsc_lane_router
    import dslsc_pkg::*;
#(
    parameter int LANES = 4
) (
    input wire logic [LANES-1:0] posInLegA,
    input wire logic [LANES-1:0] negInLegA,
    input wire logic [LANES-1:0] posInLegB,
    input wire logic [LANES-1:0] negInLegB,
    input wire logic [LANES-1:0] portAPolarity,
    input wire logic [LANES-1:0] portBPolarity,
    input wire logic [2*LANES-1:0] portALaneRoute,
    input wire logic [2*LANES-1:0] portBLaneRoute,
    input wire logic fastSourceSel,
    input wire logic fastSwitchOn,
    output logic [LANES-1:0] outPosLeg,
    output logic [LANES-1:0] outNegLeg
);

    logic [LANES-1:0] aPos, aNeg, bPos, bNeg;

    assign aPos = (posInLegA & ~portAPolarity) |
        (negInLegA & portAPolarity);
    assign aNeg = (negInLegA & ~portAPolarity) |
        (posInLegA & portAPolarity);
    assign bPos = (posInLegB & ~portBPolarity) |
        (negInLegB & portBPolarity);
    assign bNeg = (negInLegB & ~portBPolarity) |
        (posInLegB & portBPolarity);
    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_out
            logic [1:0] routeA, routeB;
            assign routeA = portALaneRoute[2*i+1:2*i];
            assign routeB = portBLaneRoute[2*i+1:2*i];
            // A lane that is off idles low so standby draws no toggling.
            assign outPosLeg[i] = fastSwitchOn &
                (fastSourceSel ? bPos[routeB] : aPos[routeA]);
            assign outNegLeg[i] = fastSwitchOn &
                (fastSourceSel ? bNeg[routeB] : aNeg[routeA]);
        end
    endgenerate

endmodule : dslsc_lane_router

`default_nettype wire

// File: hdl/dslsc_input_lane_map.sv
/*
 * Input lane map: turns the per-lane termination and equalizer bits into
 * per-source lane controls, source B lanes counted from bit 7 downward.
 * Assumes the caller registers the results.
 */
`timescale 1ns/100ps
`default_nettype none

module dslsc_input_lane_map
    import dslsc_pkg::*;
#(
    parameter int LANES = 4
) (
    input wire logic inputTermAlways,
    input wire logic [2*LANES-1:0] inputTermPerLane,
    input wire logic [2*LANES-1:0] inputEqLevel,
    output logic [LANES-1:0] termEnA,
    output logic [LANES-1:0] termEnB,
    output logic [LANES-1:0] eqHighA,
    output logic [LANES-1:0] eqHighB
);

    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            assign termEnA[i] = inputTermAlways |
                inputTermPerLane[i];
            assign termEnB[i] = inputTermAlways |
                inputTermPerLane[2*LANES-1-i];
            assign eqHighA[i] = inputEqLevel[i];
            assign eqHighB[i] = inputEqLevel[2*LANES-1-i];
        end
    endgenerate

endmodule : dslsc_input_lane_map

`default_nettype wire

// File: hdl/dslsc_config_bank.sv
/*
 * Configuration bank of a two-source lane switch: serial slave, register
 * file and registered switch controls and lane outputs.
 * Assumes the serial clock and data lines and the strap are synchronous
 * to sys_clk and that sys_clk is many times faster than the serial clock.
 */
// Operation
// - Switch enable low turns fast lanes off and enters standby.
// - Source select picks source A lanes at 0, source B at 1.
// - Lock off: low-speed source follows its own select bit only.
// - Lock on: low-speed source follows the fast source select.
// - Low-speed enable low isolates both sides; high lets it conduct.
// - Low-speed select connects side A at 0, side B at 1.
// - Termination mode 0 applies each per-lane termination bit.
// - Termination mode 1 keeps every input termination connected.
// - Per-lane bit 1 connects; bits 0-3 A0..A3, bits 4-7 B3..B0.
// - Equalizer bit picks 6 dB at 0, 12 dB at 1, same mapping.
// - Two-bit pre-emphasis picks 0, 2, 4 or 6 dB for all lanes.
// - Output termination bit turns all output terminations off/on.
// - Drive current bit picks 10 mA at 0, 20 mA at 1.
// - Source A polarity bit 1 swaps that lane's legs.
// - Source B polarity bit 1 swaps that lane's legs.
// - Source A routing field picks input lane 0..3 per output lane.
// - Source B routing field picks input lane 0..3 per output lane.
// - Slave address is fixed six bits plus strap pin as LSB.
`timescale 1ns/100ps
`default_nettype none

`include "dslsc_consts.svh"

module dslsc_config_bank
    import dslsc_pkg::*;
#(
    parameter int LANES = 4
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic addrStrap,
    input wire logic [LANES-1:0] posInLegA,
    input wire logic [LANES-1:0] negInLegA,
    input wire logic [LANES-1:0] posInLegB,
    input wire logic [LANES-1:0] negInLegB,
    output logic [LANES-1:0] outPosLeg,
    output logic [LANES-1:0] outNegLeg,
    output var dslsc_ctrl_s ctrl
);

    logic sclPrev_r;
    logic sdaPrev_r;
    logic strapBit_r;
    logic strapTaken_r;
    dslsc_ser_e serState_r;
    logic [2:0] bitCnt_r;
    logic [7:0] shift_r;
    logic ackPhase_r;
    logic readMode_r;
    logic [7:0] regPtr_r;
    logic sdaOeN_r;
    logic sdaOut_r;

    logic [7:0] fastModes_r;
    logic [7:0] lsModes_r;
    logic [7:0] rxSet_r;
    logic [7:0] inTerm_r;
    logic [7:0] inEq_r;
    logic [7:0] txSet_r;
    logic [7:0] polarity_r;
    logic [7:0] aRoute_r;
    logic [7:0] bRoute_r;

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic [7:0] rxByte;
    logic wrEn;
    logic [7:0] readData;
    logic lowspeedSel;
    logic [LANES-1:0] termEnA;
    logic [LANES-1:0] termEnB;
    logic [LANES-1:0] eqHighA;
    logic [LANES-1:0] eqHighB;
    logic [LANES-1:0] routedPos;
    logic [LANES-1:0] routedNeg;

    assign sclRise = sclIn & ~sclPrev_r;
    assign sclFall = ~sclIn & sclPrev_r;
    assign startCond = sclIn & sclPrev_r & sdaPrev_r & ~sdaIn;
    assign stopCond = sclIn & sclPrev_r & ~sdaPrev_r & sdaIn;
    assign rxByte = {shift_r[6:0], sdaIn};
    assign wrEn = (serState_r == SER_WDATA) && sclRise && (bitCnt_r == 3'h7);
    assign sdaOeN = sdaOeN_r;
    assign sdaOut = sdaOut_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclPrev_r <= sclIn;
            sdaPrev_r <= sdaIn;
        end
    end

    // The strap is taken one edge after reset release, never under reset.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            strapBit_r <= 1'b0;
            strapTaken_r <= 1'b0;
        end else if (!strapTaken_r) begin
            strapBit_r <= addrStrap;
            strapTaken_r <= 1'b1;
        end
    end

    always_comb begin
        case (regPtr_r)
            `DSLSC_OFS_FAST_MODES: readData = fastModes_r;
            `DSLSC_OFS_LS_MODES: readData = lsModes_r;
            `DSLSC_OFS_RX_SET: readData = rxSet_r;
            `DSLSC_OFS_IN_TERM: readData = inTerm_r;
            `DSLSC_OFS_IN_EQ: readData = inEq_r;
            `DSLSC_OFS_TX_SET: readData = txSet_r;
            `DSLSC_OFS_POLARITY: readData = polarity_r;
            `DSLSC_OFS_A_ROUTE: readData = aRoute_r;
            `DSLSC_OFS_B_ROUTE: readData = bRoute_r;
            default: readData = `DSLSC_UNMAPPED_READ;
        endcase
    end

    // Serial slave. Data is sampled on the clock rising edge and the data
    // line only changes after a falling edge, so start and stop stay clean.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            serState_r <= SER_IDLE;
            bitCnt_r <= 3'h0;
            shift_r <= 8'h00;
            ackPhase_r <= 1'b0;
            readMode_r <= 1'b0;
            regPtr_r <= 8'h00;
            sdaOeN_r <= 1'b1;
            sdaOut_r <= 1'b0;
        end else if (startCond) begin
            serState_r <= SER_DEV;
            bitCnt_r <= 3'h0;
            ackPhase_r <= 1'b0;
            sdaOeN_r <= 1'b1;
        end else if (stopCond) begin
            serState_r <= SER_IDLE;
            sdaOeN_r <= 1'b1;
        end else begin
            case (serState_r)
                SER_IDLE: begin
                    sdaOeN_r <= 1'b1;
                end
                SER_DEV, SER_REG, SER_WDATA: begin
                    if (sclRise) begin
                        shift_r <= rxByte;
                        bitCnt_r <= bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7) begin
                            ackPhase_r <= 1'b0;
                            if (serState_r == SER_DEV) begin
                                if (rxByte[7:1] ==
                                    {`DSLSC_SLAVE_PREFIX, strapBit_r}) begin
                                    readMode_r <= rxByte[0];
                                    serState_r <= SER_DEV_ACK;
                                end else begin
                                    serState_r <= SER_IDLE;
                                end
                            end else if (serState_r == SER_REG) begin
                                regPtr_r <= rxByte;
                                serState_r <= SER_REG_ACK;
                            end else begin
                                serState_r <= SER_WDATA_ACK;
                            end
                        end
                    end
                end
                SER_DEV_ACK, SER_REG_ACK, SER_WDATA_ACK: begin
                    if (sclFall) begin
                        if (!ackPhase_r) begin
                            ackPhase_r <= 1'b1;
                            sdaOeN_r <= 1'b0;
                        end else if (serState_r == SER_DEV_ACK &&
                            readMode_r) begin
                            bitCnt_r <= 3'h0;
                            shift_r <= readData;
                            sdaOeN_r <= readData[7];
                            serState_r <= SER_RDATA;
                        end else begin
                            bitCnt_r <= 3'h0;
                            sdaOeN_r <= 1'b1;
                            if (serState_r == SER_WDATA_ACK) begin
                                regPtr_r <= regPtr_r + 8'h01;
                            end
                            serState_r <= (serState_r == SER_DEV_ACK) ?
                                SER_REG : SER_WDATA;
                        end
                    end
                end
                SER_RDATA: begin
                    if (sclFall) begin
                        if (bitCnt_r == 3'h7) begin
                            sdaOeN_r <= 1'b1;
                            serState_r <= SER_RDATA_ACK;
                        end else begin
                            bitCnt_r <= bitCnt_r + 3'h1;
                            shift_r <= {shift_r[6:0], 1'b0};
                            sdaOeN_r <= shift_r[6];
                        end
                    end
                end
                SER_RDATA_ACK: begin
                    if (sclRise) begin
                        if (sdaIn) begin
                            serState_r <= SER_IDLE;
                        end else begin
                            regPtr_r <= regPtr_r + 8'h01;
                            serState_r <= SER_RD_LOAD;
                        end
                    end
                end
                SER_RD_LOAD: begin
                    if (sclFall) begin
                        bitCnt_r <= 3'h0;
                        shift_r <= readData;
                        sdaOeN_r <= readData[7];
                        serState_r <= SER_RDATA;
                    end
                end
                default: begin
                    serState_r <= SER_IDLE;
                    sdaOeN_r <= 1'b1;
                end
            endcase
        end
    end

    // Reserved bits are never stored, so they read back as zero.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fastModes_r <= `DSLSC_RST_FAST_MODES;
            lsModes_r <= `DSLSC_RST_LS_MODES;
            rxSet_r <= `DSLSC_RST_RX_SET;
            inTerm_r <= `DSLSC_RST_IN_TERM;
            inEq_r <= `DSLSC_RST_IN_EQ;
            txSet_r <= `DSLSC_RST_TX_SET;
            polarity_r <= `DSLSC_RST_POLARITY;
            aRoute_r <= `DSLSC_RST_A_ROUTE;
            bRoute_r <= `DSLSC_RST_B_ROUTE;
        end else if (wrEn) begin
            case (regPtr_r)
                `DSLSC_OFS_FAST_MODES: fastModes_r <= rxByte & 8'h41;
                `DSLSC_OFS_LS_MODES: lsModes_r <= rxByte & 8'hC1;
                `DSLSC_OFS_RX_SET: rxSet_r <= rxByte & 8'h01;
                `DSLSC_OFS_IN_TERM: inTerm_r <= rxByte;
                `DSLSC_OFS_IN_EQ: inEq_r <= rxByte;
                `DSLSC_OFS_TX_SET: txSet_r <= rxByte & 8'h0F;
                `DSLSC_OFS_POLARITY: polarity_r <= rxByte;
                `DSLSC_OFS_A_ROUTE: aRoute_r <= rxByte;
                `DSLSC_OFS_B_ROUTE: bRoute_r <= rxByte;
                default: fastModes_r <= fastModes_r;
            endcase
        end
    end

    assign lowspeedSel = lsModes_r[`DSLSC_LS_LOCK_BIT] ?
        fastModes_r[`DSLSC_FAST_SEL_BIT] :
        lsModes_r[`DSLSC_LS_SEL_BIT];

    dslsc_input_lane_map #(
        .LANES(LANES)
    ) u_lane_map (
        .inputTermAlways(rxSet_r[`DSLSC_TERM_ALWAYS_BIT]),
        .inputTermPerLane(inTerm_r[2*LANES-1:0]),
        .inputEqLevel(inEq_r[2*LANES-1:0]),
        .termEnA(termEnA),
        .termEnB(termEnB),
        .eqHighA(eqHighA),
        .eqHighB(eqHighB)
    );

    dslsc_lane_router #(
        .LANES(LANES)
    ) u_router (
        .posInLegA(posInLegA),
        .negInLegA(negInLegA),
        .posInLegB(posInLegB),
        .negInLegB(negInLegB),
        .portAPolarity(polarity_r[LANES-1:0]),
        .portBPolarity(polarity_r[2*LANES-1:LANES]),
        .portALaneRoute(aRoute_r[2*LANES-1:0]),
        .portBLaneRoute(bRoute_r[2*LANES-1:0]),
        .fastSourceSel(fastModes_r[`DSLSC_FAST_SEL_BIT]),
        .fastSwitchOn(fastModes_r[`DSLSC_FAST_ON_BIT]),
        .outPosLeg(routedPos),
        .outNegLeg(routedNeg)
    );

    // Lane legs are registered, trading one clock of latency for clean
    // outputs; the real lanes bypass this and only the controls matter.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            outPosLeg <= '0;
            outNegLeg <= '0;
        end else begin
            outPosLeg <= routedPos;
            outNegLeg <= routedNeg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl <= '0;
        end else begin
            ctrl.fastSwitchOn <= fastModes_r[`DSLSC_FAST_ON_BIT];
            ctrl.standby <= ~fastModes_r[`DSLSC_FAST_ON_BIT];
            ctrl.fastSourceSel <= fastModes_r[`DSLSC_FAST_SEL_BIT];
            ctrl.lowspeedConnA <= lsModes_r[`DSLSC_LS_EN_BIT] &
                ~lowspeedSel;
            ctrl.lowspeedConnB <= lsModes_r[`DSLSC_LS_EN_BIT] &
                lowspeedSel;
            ctrl.termEnA <= termEnA;
            ctrl.termEnB <= termEnB;
            ctrl.eqHighA <= eqHighA;
            ctrl.eqHighB <= eqHighB;
            ctrl.outPreemphLevel <=
                txSet_r[`DSLSC_PREEMPH_MSB:`DSLSC_PREEMPH_LSB];
            ctrl.outTermOn <= txSet_r[`DSLSC_OUT_TERM_BIT];
            ctrl.outDriveCurrent <= txSet_r[`DSLSC_OUT_CUR_BIT];
        end
    end

endmodule : dslsc_config_bank

`default_nettype wire

// File: verification/dslsc_i2c_host.sv
/* I2C host model driving the configuration bank's serial slave.
   Assumes an open-drain data line with a pull-up resolved by the bench. */
`timescale 1ns/100ps
`default_nettype none
module dslsc_i2c_host (
    input wire logic sys_clk,
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaOeN
);
    initial begin
        sclOut = 1'b1;
        sdaOeN = 1'b1;
    end
    // Each scl phase lasts four clocks, above the three the slave needs.
    task automatic phase(input logic a, input logic b, output logic r);
        sclOut <= 1'b0;
        repeat (2) @(posedge sys_clk);
        sdaOeN <= a;
        repeat (2) @(posedge sys_clk);
        sclOut <= 1'b1;
        repeat (2) @(posedge sys_clk);
        r = sdaLine;
        sdaOeN <= b;
        repeat (2) @(posedge sys_clk);
    endtask : phase
    // The ninth bit is released, so a read byte always ends in a NACK.
    task automatic xfer(input logic [7:0] d, output logic [7:0] q,
        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            phase(d[i], d[i], q[i]);
        end
        phase(1'b1, 1'b1, r);
        ack = ~r;
    endtask : xfer
    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs,
        input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic [2:0] a;
        phase(1'b1, 1'b0, q[0]);
        xfer({dev, 1'b0}, q, a[0]);
        xfer(ofs, q, a[1]);
        xfer(d, q, a[2]);
        phase(1'b0, 1'b1, q[0]);
        ok = &a;
    endtask : wr
    task automatic rd(input logic [6:0] dev, input logic [7:0] ofs,
        output logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic [3:0] a;
        phase(1'b1, 1'b0, q[0]);
        xfer({dev, 1'b0}, q, a[0]);
        xfer(ofs, q, a[1]);
        phase(1'b1, 1'b0, q[0]);
        xfer({dev, 1'b1}, q, a[2]);
        xfer(8'hFF, d, a[3]);
        phase(1'b0, 1'b1, q[0]);
        ok = &a[2:0];
    endtask : rd
endmodule : dslsc_i2c_host
`default_nettype wire

// File: verification/dslsc_config_bank_chk.sv
/* Port assertions of the lane switch configuration bank.
   Bound to dslsc_config_bank; one clock, synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module dslsc_config_bank_chk
    import dslsc_pkg::*;
#(
    parameter int LANES = 4
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sclIn,
    input wire logic sdaOeN,
    input wire logic [LANES-1:0] posInLegA,
    input wire logic [LANES-1:0] negInLegA,
    input wire logic [LANES-1:0] posInLegB,
    input wire logic [LANES-1:0] negInLegB,
    input wire logic [LANES-1:0] outPosLeg,
    input wire logic [LANES-1:0] outNegLeg,
    input wire dslsc_ctrl_s ctrl
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // Two cycles of one selection, so the registered lanes have caught up.
    sequence heldOn(s);
        ctrl.fastSwitchOn && ctrl.fastSourceSel == s ##1
            ctrl.fastSwitchOn && ctrl.fastSourceSel == s;
    endsequence
    standby_pair_a: assert property (
        $past(rst_b) |-> ctrl.standby != ctrl.fastSwitchOn)
        else $error("standby does not oppose switch enable");
    lanes_off_a: assert property (
        !ctrl.fastSwitchOn && !$past(ctrl.fastSwitchOn)
        |-> outPosLeg == '0 && outNegLeg == '0)
        else $error("lanes driven while switched off");
    lowspeed_excl_a: assert property (
        !(ctrl.lowspeedConnA && ctrl.lowspeedConnB))
        else $error("both low-speed sides connected");
    ctrl_on_scl_a: assert property (
        $changed(ctrl) && $past(rst_b) |-> $past(sclIn))
        else $error("controls changed outside a serial bit");
    ack_on_low_a: assert property (
        $changed(sdaOeN) |-> !$past(sclIn))
        else $error("data line changed while clock high");
    src_a_ones_a: assert property (
        heldOn(1'b0) ##0 ($past(posInLegA & negInLegA) == '1)
        |-> outPosLeg == '1 && outNegLeg == '1)
        else $error("source A lanes not routed");
    src_b_ones_a: assert property (
        heldOn(1'b1) ##0 ($past(posInLegB & negInLegB) == '1)
        |-> outPosLeg == '1 && outNegLeg == '1)
        else $error("source B lanes not routed");
    src_a_zero_a: assert property (
        heldOn(1'b0) ##0 ($past(posInLegA | negInLegA) == '0)
        |-> outPosLeg == '0 && outNegLeg == '0)
        else $error("lanes taken from unselected source");
endmodule : dslsc_config_bank_chk
bind dslsc_config_bank dslsc_config_bank_chk #(.LANES(LANES)) chk_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .sclIn(sclIn), .sdaOeN(sdaOeN),
    .posInLegA(posInLegA), .negInLegA(negInLegA), .posInLegB(posInLegB),
    .negInLegB(negInLegB), .outPosLeg(outPosLeg), .outNegLeg(outNegLeg),
    .ctrl(ctrl)
);
`default_nettype wire

// File: verification/dslsc_config_bank_test.sv
/* Self-checking bench of the lane switch configuration bank.
   Assumes the I2C host model and the checker are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module dslsc_config_bank_test
    import dslsc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic addrStrap = 1'b1;
    logic [3:0] posA = '0, negA = '0, posB = '0, negB = '0;
    logic sclIn, hostOeN, sdaOut, sdaOeN;
    logic [3:0] outP, outN;
    dslsc_ctrl_s ctrl;
    int badCount = 0, totalChecks = 0, cycles = 0;
    // Open drain with a pull-up: any party enabling pulls the line low.
    wire logic sdaLine = hostOeN & (sdaOeN | sdaOut);
    logic [7:0] ofsT [9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h14, 8'h20,
        8'h80, 8'h81, 8'h82};
    logic [7:0] dfltT [9] = '{8'h40, 8'hC0, 8'h01, 8'h00, 8'hFF, 8'h03,
        8'h00, 8'hE4, 8'hE4};
    logic [7:0] mskT [9] = '{8'h41, 8'hC1, 8'h01, 8'hFF, 8'hFF, 8'h0F,
        8'hFF, 8'hFF, 8'hFF};
    initial forever #12.5 sys_clk = ~sys_clk;
    dslsc_i2c_host host_u (.sys_clk(sys_clk), .sdaLine(sdaLine),
        .sclOut(sclIn), .sdaOeN(hostOeN));
    dslsc_config_bank #(.LANES(4)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .addrStrap(addrStrap), .posInLegA(posA), .negInLegA(negA),
        .posInLegB(posB), .negInLegB(negB), .outPosLeg(outP),
        .outNegLeg(outN), .ctrl(ctrl));
    task automatic endSim();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : endSim
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 80000) begin
            badCount++;
            endSim();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic ok;
        host_u.wr({6'h24, addrStrap}, ofs, d, ok);
        chk("write ack", 1, ok);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic ok;
        logic [7:0] q;
        host_u.rd({6'h24, addrStrap}, ofs, q, ok);
        chk("read ack", 1, ok);
        chk("read data", exp, q);
    endtask : rd
    task automatic doReset(input logic s);
        addrStrap <= s;
        rst_b <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : doReset
    function automatic logic [7:0] route(input logic [3:0] p,
        input logic [3:0] n, input logic [3:0] pol, input logic [7:0] map);
        logic [7:0] r;
        logic [1:0] j;
        for (int i = 0; i < 4; i++) begin
            j = map[2*i+:2];
            r[i+4] = pol[j] ? n[j] : p[j];
            r[i] = pol[j] ? p[j] : n[j];
        end
        return r;
    endfunction : route
    task automatic legs(input logic [15:0] v, input logic [7:0] exp);
        {posA, negA, posB, negB} <= v;
        repeat (3) @(posedge sys_clk);
        chk("lanes", exp, {outP, outN});
    endtask : legs
    task automatic t_regs();
        chk("ctrl reset", {5'b10010, 16'hFFFF, 4'h3}, ctrl);
        for (int i = 0; i < 9; i++) begin
            rd(ofsT[i], dfltT[i]);
            wr(ofsT[i], 8'h5A);
            rd(ofsT[i], 8'h5A & mskT[i]);
        end
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
    endtask : t_regs
    task automatic t_modes();
        logic [3:0] v;
        logic eff;
        for (int k = 0; k < 16; k++) begin
            v = k[3:0];
            eff = v[2] ? v[3] : v[0];
            wr(8'h00, {2'b01, 5'b0, v[3]});
            wr(8'h01, {v[2], v[1], 5'b0, v[0]});
            chk("connA", v[1] & ~eff, ctrl.lowspeedConnA);
            chk("connB", v[1] & eff, ctrl.lowspeedConnB);
            chk("fast sel", v[3], ctrl.fastSourceSel);
            rd(8'h01, {v[2], v[1], 5'b0, v[0]});
        end
        wr(8'h00, 8'h00);
        chk("standby", 2'b01, {ctrl.fastSwitchOn, ctrl.standby});
        wr(8'h00, 8'h40);
        chk("standby", 2'b10, {ctrl.fastSwitchOn, ctrl.standby});
    endtask : t_modes
    task automatic t_rx();
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h2D);
        chk("term", 8'hD4, {ctrl.termEnA, ctrl.termEnB});
        wr(8'h10, 8'h01);
        chk("term", 8'hFF, {ctrl.termEnA, ctrl.termEnB});
        wr(8'h14, 8'h2D);
        chk("eq", 8'hD4, {ctrl.eqHighA, ctrl.eqHighB});
    endtask : t_rx
    task automatic t_tx();
        logic [1:0] p;
        for (int k = 0; k < 4; k++) begin
            p = k[1:0];
            wr(8'h20, {4'h0, p, p[0], ~p[0]});
            chk("tx", {p, p[0], ~p[0]}, {ctrl.outPreemphLevel,
                ctrl.outTermOn, ctrl.outDriveCurrent});
        end
    endtask : t_tx
    task automatic t_lanes();
        wr(8'h80, 8'h6C);
        wr(8'h81, 8'h1B);
        wr(8'h82, 8'h4E);
        wr(8'h00, 8'h40);
        legs(16'h539A, route(4'h5, 4'h3, 4'hC, 8'h1B));
        wr(8'h00, 8'h41);
        legs(16'h539A, route(4'h9, 4'hA, 4'h6, 8'h4E));
        legs(16'h00FF, 8'hFF);
        wr(8'h00, 8'h40);
        legs(16'h00FF, 8'h00);
        legs(16'hFF00, 8'hFF);
        wr(8'h00, 8'h00);
        legs(16'hFF00, 8'h00);
    endtask : t_lanes
    task automatic t_addr();
        logic ok;
        host_u.wr({6'h24, ~addrStrap}, 8'h81, 8'h00, ok);
        chk("foreign ack", 0, ok);
        rd(8'h81, 8'h1B);
        doReset(1'b0);
        rd(8'h81, 8'hE4);
    endtask : t_addr
    initial begin
        doReset(1'b1);
        t_regs();
        t_modes();
        t_rx();
        t_tx();
        t_lanes();
        t_addr();
        endSim();
    end
endmodule : dslsc_config_bank_test
`default_nettype wire
